// [core/rpf_reset_status_filter.sv]
/*
 * Reset cause status and reset pin filter setup of a reset controller.
 * Holds the second reset cause register, the filter control and width
 * registers, an interrupt status and mask pair, and two pin filters.
 * Assumes: rst is synchronous and high while any chip reset is active,
 * por is high with rst during a power-on reset only, the cause inputs
 * and reset_kind are valid while rst is high, and the reset pin and the
 * low-power-oscillator clock are asynchronous to clk.
 */
`timescale 1ns/1ps
`include "rpf_cfg.svh"

// Summary of operation
// - Second cause register is read-only flags
// - Power-on, voltage, deep-stop wakeup clear causes
// - Other resets set only their source flag
// - Bit 5 marks stop acknowledge timeout reset
// - Bit 3 marks debugger reset request
// - Bit 2 marks software reset request
// - Bit 1 marks core lockup reset
// - Reserved bits always read zero
// - Filter control kept except power-on reset
// - Bus filter cleared when off or stopping
// - Oscillator filter cleared when off
// - Bit 2 picks stop-mode filtering
// - Bits 1:0 pick run/wait filtering
// - Filter width kept except power-on reset
// - Bus filter count is width plus one
module rpf_reset_status_filter #(
    parameter int LPO_COUNT = `RPF_LPO_COUNT
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         por,
    input  wire rpf_pkg::rpf_reset_kind_t     reset_kind,
    input  wire logic                         stop_ack_timeout,
    input  wire logic                         debugger_reset_req,
    input  wire logic                         core_system_reset_request,
    input  wire logic                         core_lockup,
    input  wire rpf_pkg::rpf_power_mode_t     power_mode,
    input  wire logic                         lpo_clk_in,
    input  wire logic                         reset_pin_n_in,
    input  wire logic [`RPF_ADDR_W-1:0]       bus_addr,
    input  wire logic [`RPF_DATA_W-1:0]       bus_wdata,
    input  wire logic                         bus_wr,
    input  wire logic                         bus_rd,
    output logic      [`RPF_DATA_W-1:0]       bus_rdata,
    output logic                              reset_pin_filtered_n,
    output logic                              irq
);
    localparam int LPO_CW = (LPO_COUNT > 1) ? $clog2(LPO_COUNT) : 1;

    if (LPO_COUNT < 1) begin : g_bad_lpo_count
        $error("rpf_reset_status_filter: LPO_COUNT must be at least 1");
    end

    // Registers
    logic [`RPF_DATA_W-1:0]   cause_reg;
    logic [`RPF_FCTRL_W-1:0]  fctrl_reg;
    logic [`RPF_FWIDTH_W-1:0] fwidth_reg;
    logic [`RPF_EV_W-1:0]     irq_stat_reg;
    logic [`RPF_EV_W-1:0]     irq_mask_reg;
    logic [`RPF_EV_W-1:0]     irq_stat_next;
    logic [`RPF_DATA_W-1:0]   rdata_next;

    // Pin and oscillator sampling
    logic [1:0]               sync_q;
    logic                     pin_s;
    logic                     lpo_s;
    logic                     lpo_prev_reg;
    logic                     lpo_tick;

    // Mode and selection
    logic                     in_stop;
    logic                     was_stop_reg;
    logic                     stop_entry;
    logic [1:0]               rw_sel;
    logic                     stop_sel;
    logic                     bus_en;
    logic                     lpo_en;
    logic                     filt_level;
    logic                     filt_prev_reg;

    // Bus decode
    logic [`RPF_IDX_W-1:0]    idx;
    logic                     aligned;
    logic                     wr_fctrl;
    logic                     wr_fwidth;
    logic                     wr_stat;
    logic                     wr_mask;
    logic [`RPF_EV_W-1:0]     events;

    rpf_filt_if #(.CNT_W(`RPF_FWIDTH_W)) bus_fif ();
    rpf_filt_if #(.CNT_W(LPO_CW))        lpo_fif ();

    // Pin and oscillator both reset high; both synchronised
    rpf_sync #(
        .WIDTH     (2),
        .RESET_VAL (1'b1)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({lpo_clk_in, reset_pin_n_in}),
        .sync_out (sync_q)
    );

    assign pin_s = sync_q[0];
    assign lpo_s = sync_q[1];

    // Rising edge of the oscillator gives the slow filter its sample tick
    always_ff @(posedge clk) begin
        if (rst) begin
            lpo_prev_reg <= 1'b1;
        end else begin
            lpo_prev_reg <= lpo_s;
        end
    end

    assign lpo_tick = lpo_s & ~lpo_prev_reg;

    // Address decode; byte address is index times four
    assign idx       = bus_addr[`RPF_ADDR_W-1:2];
    assign aligned   = (bus_addr[1:0] == 2'h0);
    assign wr_fctrl  = bus_wr && aligned && (idx == `RPF_IDX_FCTRL);
    assign wr_fwidth = bus_wr && aligned && (idx == `RPF_IDX_FWIDTH);
    assign wr_stat   = bus_wr && aligned && (idx == `RPF_IDX_IRQ_STAT);
    assign wr_mask   = bus_wr && aligned && (idx == `RPF_IDX_IRQ_MASK);

    // Capture the reset cause while the chip reset is active
    always_ff @(posedge clk) begin
        if (por) begin
            cause_reg <= '0;
        end else if (rst) begin
            cause_reg <= '0;
            case (reset_kind)
                rpf_pkg::rk_power_on,
                rpf_pkg::rk_low_voltage_detect,
                rpf_pkg::rk_very_low_leakage_stop_wakeup: begin
                    cause_reg <= '0;
                end
                rpf_pkg::rk_other: begin
                    // One flag only, highest source wins
                    if (stop_ack_timeout) begin
                        cause_reg[`RPF_BIT_STOP_ACK] <= 1'b1;
                    end else if (debugger_reset_req) begin
                        cause_reg[`RPF_BIT_DEBUGGER] <= 1'b1;
                    end else if (core_system_reset_request) begin
                        cause_reg[`RPF_BIT_SOFTWARE] <= 1'b1;
                    end else if (core_lockup) begin
                        cause_reg[`RPF_BIT_LOCKUP] <= 1'b1;
                    end
                end
                default: begin
                    cause_reg <= '0;
                end
            endcase
        end
    end

    // Filter control survives every reset but power-on
    always_ff @(posedge clk) begin
        if (por) begin
            fctrl_reg <= `RPF_FCTRL_RST;
        end else if (wr_fctrl) begin
            fctrl_reg <= bus_wdata[`RPF_FCTRL_W-1:0];
        end
    end

    // Filter width survives every reset but power-on
    always_ff @(posedge clk) begin
        if (por) begin
            fwidth_reg <= `RPF_FWIDTH_RST;
        end else if (wr_fwidth) begin
            fwidth_reg <= bus_wdata[`RPF_FWIDTH_W-1:0];
        end
    end

    // Mode tracking for stop entry
    assign in_stop = (power_mode == rpf_pkg::pm_stop) ||
                     (power_mode == rpf_pkg::pm_very_low_power_stop) ||
                     (power_mode == rpf_pkg::pm_low_leakage_stop) ||
                     (power_mode == rpf_pkg::pm_very_low_leakage_stop);

    always_ff @(posedge clk) begin
        if (rst) begin
            was_stop_reg <= 1'b0;
        end else begin
            was_stop_reg <= in_stop;
        end
    end

    assign stop_entry = in_stop & ~was_stop_reg;

    // Filter selection by mode; the reserved run/wait code filters nothing
    assign rw_sel   = fctrl_reg[`RPF_RW_LSB +: 2];
    assign stop_sel = fctrl_reg[`RPF_BIT_STOP_SEL];
    assign bus_en   = ~in_stop && (rw_sel == `RPF_RW_BUS);
    assign lpo_en   = in_stop ? stop_sel : (rw_sel == `RPF_RW_LPO);

    // Bus-clock filter hookup
    assign bus_fif.tick     = 1'b1;
    assign bus_fif.clear    = ~bus_en | stop_entry;
    assign bus_fif.raw      = pin_s;
    assign bus_fif.count_m1 = fwidth_reg;

    // Oscillator filter hookup
    assign lpo_fif.tick     = lpo_tick;
    assign lpo_fif.clear    = ~lpo_en;
    assign lpo_fif.raw      = pin_s;
    assign lpo_fif.count_m1 = LPO_CW'(LPO_COUNT - 1);

    rpf_pin_filter u_bus_filter (
        .clk (clk),
        .rst (rst),
        .fif (bus_fif)
    );

    rpf_pin_filter u_lpo_filter (
        .clk (clk),
        .rst (rst),
        .fif (lpo_fif)
    );

    // Pick the active filter or the bare synchronised pin
    always_comb begin
        if (bus_en) begin
            filt_level = bus_fif.filt;
        end else if (lpo_en) begin
            filt_level = lpo_fif.filt;
        end else begin
            filt_level = pin_s;
        end
    end

    // Registered filtered pin and edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_pin_filtered_n <= 1'b1;
            filt_prev_reg        <= 1'b1;
        end else begin
            reset_pin_filtered_n <= filt_level;
            filt_prev_reg        <= reset_pin_filtered_n;
        end
    end

    // Events: pin asserted, pin released, reserved select written
    always_comb begin
        events = '0;
        events[`RPF_EV_PIN_ASSERT]  = filt_prev_reg & ~reset_pin_filtered_n;
        events[`RPF_EV_PIN_RELEASE] = ~filt_prev_reg & reset_pin_filtered_n;
        events[`RPF_EV_RSVD_SEL]    = wr_fctrl && (bus_wdata[`RPF_RW_LSB +: 2] == `RPF_RW_RSVD);
    end

    // Sticky status, write one to clear, a new event beats the clear
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_stat) begin
            irq_stat_next = irq_stat_reg & ~bus_wdata[`RPF_EV_W-1:0];
        end
        irq_stat_next = irq_stat_next | events;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= `RPF_EV_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_reg <= `RPF_EV_RST;
        end else if (wr_mask) begin
            irq_mask_reg <= bus_wdata[`RPF_EV_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_next = '0;
        if (bus_rd && aligned) begin
            case (idx)
                `RPF_IDX_CAUSE:    rdata_next = cause_reg;
                `RPF_IDX_FCTRL:    rdata_next[`RPF_FCTRL_W-1:0] = fctrl_reg;
                `RPF_IDX_FWIDTH:   rdata_next[`RPF_FWIDTH_W-1:0] = fwidth_reg;
                `RPF_IDX_IRQ_STAT: rdata_next[`RPF_EV_W-1:0] = irq_stat_reg;
                `RPF_IDX_IRQ_MASK: rdata_next[`RPF_EV_W-1:0] = irq_mask_reg;
                default:           rdata_next = '0;
            endcase
        end
    end

    // Read data stands for one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= rdata_next;
        end
    end
endmodule : rpf_reset_status_filter

// [core/rpf_cfg.svh]
/*
 * Register map, field positions, reset values and counts of the reset
 * status and reset pin filter block.
 * Assumes an 8-bit register bus whose byte address is four times the index.
 */
`ifndef RPF_CFG_SVH
`define RPF_CFG_SVH

// Bus geometry
`define RPF_ADDR_W          8
`define RPF_DATA_W          8
`define RPF_IDX_W           6

// Register indices; byte address is index times four
`define RPF_IDX_CAUSE       6'h01
`define RPF_IDX_FCTRL       6'h04
`define RPF_IDX_FWIDTH      6'h05
`define RPF_IDX_IRQ_STAT    6'h06
`define RPF_IDX_IRQ_MASK    6'h07

// Reset cause flag positions
`define RPF_BIT_STOP_ACK    5
`define RPF_BIT_DEBUGGER    3
`define RPF_BIT_SOFTWARE    2
`define RPF_BIT_LOCKUP      1

// Filter control fields
`define RPF_FCTRL_W         3
`define RPF_BIT_STOP_SEL    2
`define RPF_RW_LSB          0
`define RPF_FCTRL_RST       3'h0
`define RPF_RW_OFF          2'h0
`define RPF_RW_BUS          2'h1
`define RPF_RW_LPO          2'h2
`define RPF_RW_RSVD         2'h3

// Filter width field
`define RPF_FWIDTH_W        5
`define RPF_FWIDTH_RST      5'h00

// Interrupt events
`define RPF_EV_W            3
`define RPF_EV_PIN_ASSERT   0
`define RPF_EV_PIN_RELEASE  1
`define RPF_EV_RSVD_SEL     2
`define RPF_EV_RST          3'h0

// Low-power-oscillator filter count in oscillator cycles
`define RPF_LPO_COUNT       3

`endif

// [core/rpf_pkg.sv]
/*
 * Types of the reset status and reset pin filter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rpf_pkg;

    // Power mode reported by the mode controller
    typedef enum logic [2:0] {
        pm_run,
        pm_wait,
        pm_stop,
        pm_very_low_power_stop,
        pm_low_leakage_stop,
        pm_very_low_leakage_stop
    } rpf_power_mode_t;

    // Kind of chip reset, valid while rst is high
    typedef enum logic [1:0] {
        rk_power_on,
        rk_low_voltage_detect,
        rk_very_low_leakage_stop_wakeup,
        rk_other
    } rpf_reset_kind_t;

endpackage : rpf_pkg

// [core/rpf_filt_if.sv]
/*
 * Link between the control logic and one reset pin glitch filter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface rpf_filt_if #(
    parameter int CNT_W = 5
);
    logic             tick;      // Filter sample strobe
    logic             clear;     // Forces filter state back to idle
    logic             raw;       // Synchronised pin level
    logic [CNT_W-1:0] count_m1;  // Required stable samples minus one
    logic             filt;      // Filtered pin level

    modport filt_end (input tick, input clear, input raw, input count_m1, output filt);
    modport ctl_end  (output tick, output clear, output raw, output count_m1, input filt);
endinterface : rpf_filt_if

// [core/rpf_sync.sv]
/*
 * Two flip-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs change slowly against clk.
 */
`timescale 1ns/1ps

module rpf_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [0:0] RESET_VAL = 1'b0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("rpf_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= {WIDTH{RESET_VAL}};
            sync_out <= {WIDTH{RESET_VAL}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : rpf_sync

// [core/rpf_pin_filter.sv]
/*
 * One reset pin glitch filter: the output follows the input only after
 * the input has held a new level for count_m1+1 consecutive ticks.
 * Assumes raw is already synchronised to clk.
 */
`timescale 1ns/1ps

module rpf_pin_filter (
    input  wire logic clk,
    input  wire logic rst,
    rpf_filt_if.filt_end fif
);
    localparam int CW = $bits(fif.count_m1);

    logic [CW-1:0] cnt_reg;
    logic          filt_reg;

    assign fif.filt = filt_reg;

    // Count agreeing samples, flip after the full run
    always_ff @(posedge clk) begin
        if (rst || fif.clear) begin
            cnt_reg  <= '0;
            filt_reg <= fif.raw;
        end else if (fif.tick) begin
            if (fif.raw == filt_reg) begin
                cnt_reg <= '0;
            end else if (cnt_reg >= fif.count_m1) begin
                cnt_reg  <= '0;
                filt_reg <= fif.raw;
            end else begin
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end
endmodule : rpf_pin_filter

// [testbench/rpf_asserts.sv]
/*
 * Port checks of the reset status and pin filter block.
 * Assumes it is bound to rpf_reset_status_filter, one clock domain.
 */
`timescale 1ns/1ps

module rpf_asserts #(
    parameter int LPO_COUNT = 3
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     por,
    input wire rpf_pkg::rpf_power_mode_t power_mode,
    input wire logic                     reset_pin_n_in,
    input wire logic [7:0]               bus_addr,
    input wire logic [7:0]               bus_wdata,
    input wire logic                     bus_wr,
    input wire logic                     bus_rd,
    input wire logic [7:0]               bus_rdata,
    input wire logic                     reset_pin_filtered_n,
    input wire logic                     irq
);
    logic       rd_q;
    logic [7:0] a_q;
    logic [2:0] fc;
    logic [4:0] fw;
    logic [2:0] msk;
    logic       cfg_ok;
    logic       por_seen;
    logic       cvalid;
    logic [7:0] clast;
    logic [5:0] lo_cnt;
    logic [5:0] lo_last;
    wire        rd_cause = rd_q && a_q == 8'h04;
    wire        rd_fc    = rd_q && a_q == 8'h10;
    wire        wr_ok    = bus_wr && !rst;
    wire        run_bus  = fc[1:0] == 2'h1 && power_mode == rpf_pkg::pm_run;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Read strobe and address of the previous cycle
    always_ff @(posedge clk) begin
        rd_q <= bus_rd && !rst;
        a_q  <= bus_addr;
    end

    // Expected filter setup, only a power-on clears it
    always_ff @(posedge clk) begin
        if (rst && por) begin
            fc     <= 3'h0;
            fw     <= 5'h00;
            cfg_ok <= 1'b1;
        end else if (wr_ok && bus_addr == 8'h10) begin
            fc <= bus_wdata[2:0];
        end else if (wr_ok && bus_addr == 8'h14) begin
            fw <= bus_wdata[4:0];
        end
    end

    // Expected interrupt mask
    always_ff @(posedge clk) begin
        if (rst)
            msk <= 3'h0;
        else if (bus_wr && bus_addr == 8'h1c)
            msk <= bus_wdata[2:0];
    end

    // Kind of last reset and latest cause value read since it
    always_ff @(posedge clk) begin
        if (rst) begin
            por_seen <= por;
            cvalid   <= 1'b0;
        end else if (rd_cause) begin
            cvalid <= 1'b1;
            clast  <= bus_rdata;
        end
    end

    // Length of the current and of the last low pulse on the raw pin
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_cnt  <= 6'h00;
            lo_last <= 6'h00;
        end else if (!reset_pin_n_in) begin
            lo_cnt <= lo_cnt + {5'h00, lo_cnt != 6'h3f};
            if (lo_cnt == 6'h00)
                lo_last <= 6'h00;
        end else begin
            lo_cnt <= 6'h00;
            if (lo_cnt != 6'h00)
                lo_last <= lo_cnt;
        end
    end

    a_rdata_quiet: assert property (bus_rdata != 8'h00 |-> rd_q)
        else $error("read data outside the answer cycle");
    a_cause_rsvd: assert property (rd_cause |-> (bus_rdata & 8'hd1) == 8'h00)
        else $error("reserved cause bit set");
    a_cause_onehot: assert property (rd_cause |-> $onehot0(bus_rdata))
        else $error("more than one cause flag");
    a_cause_kept: assert property (rd_cause && cvalid |-> bus_rdata == clast)
        else $error("cause flags changed without reset");
    a_cause_cleared: assert property (rd_cause && por_seen |-> bus_rdata == 8'h00)
        else $error("cause flags not clear after power-on");
    a_fctrl_kept: assert property (rd_fc && cfg_ok |-> bus_rdata == {5'h00, fc})
        else $error("filter control read wrong");
    a_fwidth_kept: assert property (rd_q && a_q == 8'h14 && cfg_ok |-> bus_rdata == {3'h0, fw})
        else $error("filter width read wrong");
    a_bus_hold: assert property ($fell(reset_pin_filtered_n) && run_bus |->
        (lo_cnt > {1'b0, fw} || lo_last > {1'b0, fw}))
        else $error("bus filter passed a short pulse");
    a_irq_masked: assert property (irq |-> msk != 3'h0)
        else $error("interrupt with all events masked");
endmodule : rpf_asserts

bind rpf_reset_status_filter rpf_asserts #(.LPO_COUNT(LPO_COUNT)) u_chk (
    .clk, .rst, .por, .power_mode, .reset_pin_n_in, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .reset_pin_filtered_n, .irq
);

// [testbench/rpf_pin_model.sv]
/*
 * External reset pin with pull-up and free-running oscillator clock.
 * Assumes the caller starts pulses from its own clock.
 */
`timescale 1ns/1ps

module rpf_pin_model (
    input  wire logic clk,
    output logic      lpo_clk,
    output logic      pin_n
);
    initial lpo_clk = 1'b0;
    initial pin_n = 1'b1;

    // Oscillator phase unrelated to clk
    always #15.5 lpo_clk = ~lpo_clk;

    // Pulls the pin low for n cycles, then the pull-up wins again
    task automatic pulse(input int n);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (n) @(posedge clk);
        pin_n <= 1'b1;
    endtask : pulse
endmodule : rpf_pin_model

// [testbench/rpf_reset_status_filter_tb_top.sv]
/*
 * Self-checking bench of the reset status and pin filter block.
 * Assumes the pin model drives the reset pin and the oscillator clock.
 */
`timescale 1ns/1ps

module rpf_reset_status_filter_tb_top;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     por = 1'b1;
    rpf_pkg::rpf_reset_kind_t reset_kind = rpf_pkg::rk_power_on;
    rpf_pkg::rpf_power_mode_t power_mode = rpf_pkg::pm_run;
    logic [3:0]               src = 4'h0;
    logic [7:0]               bus_addr = 8'h00;
    logic [7:0]               bus_wdata = 8'h00;
    logic                     bus_wr = 1'b0;
    logic                     bus_rd = 1'b0;
    logic [7:0]               bus_rdata;
    logic                     filt_n;
    logic                     irq;
    logic                     lpo_clk;
    logic                     pin_n;
    logic                     saw_low = 1'b0;
    logic                     rd_seen = 1'b0;
    logic [7:0]               exp_q[$];
    logic [7:0]               cause_bit[4] = '{8'h20, 8'h08, 8'h04, 8'h02};
    logic [2:0]               fc;
    logic [4:0]               fw;
    int                       n_errors = 0;
    int                       check_count = 0;
    int                       seed = 87236;

    always #2.5 clk = ~clk;

    rpf_pin_model u_pin (.clk(clk), .lpo_clk(lpo_clk), .pin_n(pin_n));

    rpf_reset_status_filter #(.LPO_COUNT(2)) u_dut (
        .clk(clk), .rst(rst), .por(por), .reset_kind(reset_kind),
        .stop_ack_timeout(src[3]), .debugger_reset_req(src[2]),
        .core_system_reset_request(src[1]), .core_lockup(src[0]),
        .power_mode(power_mode), .lpo_clk_in(lpo_clk), .reset_pin_n_in(pin_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .reset_pin_filtered_n(filt_n), .irq(irq)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Answer watcher: oldest note against the cycle after each read
    always @(posedge clk) begin
        if (rd_seen)
            chk(bus_rdata, exp_q.pop_front());
        rd_seen = bus_rd;
        if (filt_n === 1'b0)
            saw_low = 1'b1;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        bus_rd   <= 1'b0;
    endtask : rd

    task automatic rst_chip(input logic p, input rpf_pkg::rpf_reset_kind_t k, input logic [3:0] s);
        @(posedge clk);
        rst        <= 1'b1;
        por        <= p;
        reset_kind <= k;
        src        <= s;
        repeat (4) @(posedge clk);
        rst        <= 1'b0;
        por        <= 1'b0;
        src        <= 4'h0;
    endtask : rst_chip

    // One filter setup, one pin pulse, was the pulse let through
    task automatic row(input rpf_pkg::rpf_power_mode_t m, input logic [2:0] c, input logic [4:0] w,
                       input int n, input logic e);
        wr(8'h10, {5'h00, c});
        wr(8'h14, {3'h0, w});
        power_mode <= m;
        repeat (5) @(posedge clk);
        saw_low = 1'b0;
        u_pin.pulse(n);
        repeat (n + 80) @(posedge clk);
        chk({7'h00, saw_low}, {7'h00, e});
    endtask : row

    task automatic irq_is(input logic e);
        @(negedge clk);
        chk({7'h00, irq}, {7'h00, e});
    endtask : irq_is

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        rd(8'h04, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h00);
        $display("test done: power-on state");
        for (int i = 0; i < 6; i++) begin
            fc = 3'($random(seed));
            fw = 5'($random(seed));
            wr(8'h10, {5'h00, fc});
            wr(8'h14, {3'h0, fw});
            rst_chip(1'b0, i < 4 ? rpf_pkg::rk_other : (i == 4 ? rpf_pkg::rk_low_voltage_detect
                     : rpf_pkg::rk_very_low_leakage_stop_wakeup), i < 4 ? 4'h8 >> i : 4'hf);
            rd(8'h04, i < 4 ? cause_bit[i] : 8'h00);
            rd(8'h10, {5'h00, fc});
            rd(8'h14, {3'h0, fw});
        end
        rst_chip(1'b1, rpf_pkg::rk_power_on, 4'hf);
        rd(8'h04, 8'h00);
        rd(8'h10, 8'h00);
        $display("test done: reset causes");
        row(rpf_pkg::pm_run, 3'h0, 5'h00, 3, 1'b1);
        row(rpf_pkg::pm_run, 3'h1, 5'h07, 7, 1'b0);
        row(rpf_pkg::pm_run, 3'h1, 5'h1f, 32, 1'b1);
        row(rpf_pkg::pm_run, 3'h2, 5'h00, 3, 1'b0);
        row(rpf_pkg::pm_run, 3'h3, 5'h00, 3, 1'b1);
        row(rpf_pkg::pm_wait, 3'h1, 5'h07, 3, 1'b0);
        row(rpf_pkg::pm_stop, 3'h4, 5'h07, 3, 1'b0);
        row(rpf_pkg::pm_stop, 3'h1, 5'h07, 3, 1'b1);
        row(rpf_pkg::pm_very_low_power_stop, 3'h4, 5'h00, 3, 1'b0);
        row(rpf_pkg::pm_low_leakage_stop, 3'h0, 5'h00, 3, 1'b1);
        row(rpf_pkg::pm_very_low_leakage_stop, 3'h4, 5'h00, 60, 1'b1);
        // Stop select set again before the deep stop is left
        wr(8'h10, 8'h04);
        power_mode <= rpf_pkg::pm_run;
        $display("test done: pin filters");
        // Events: pin asserted, pin released, reserved select written
        rd(8'h18, 8'h07);
        irq_is(1'b0);
        wr(8'h1c, 8'h02);
        irq_is(1'b1);
        wr(8'h18, 8'h02);
        irq_is(1'b0);
        rd(8'h18, 8'h05);
        wr(8'h1c, 8'h07);
        irq_is(1'b1);
        wr(8'h18, 8'h07);
        irq_is(1'b0);
        rd(8'h18, 8'h00);
        $display("test done: interrupts");
        repeat (3) @(posedge clk);
        complete_run();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule : rpf_reset_status_filter_tb_top
